// [verilog/alt_pkg.sv]
// package of constants for the accumulator load transfer block
`default_nettype none
package alt_pkg;
  localparam int unsigned ALT_DATA_W = 4;
  localparam int unsigned ALT_Z_W    = 2;
  localparam int unsigned ALT_INSN_W = 10;
  localparam logic [9:0] ALT_OP_TIMER_SIX = 10'h250;
  localparam logic [9:0] ALT_OP_X         = 10'h052;
  localparam logic [9:0] ALT_OP_Y         = 10'h01f;
  localparam logic [9:0] ALT_OP_Z         = 10'h053;
  localparam logic [3:0] ALT_ACC_RESET    = 4'h0;
  localparam logic [1:0] ALT_ZEXT_HI      = 2'h0;
  typedef enum logic [2:0] {
    ALT_SRC_NONE  = 3'b000,
    ALT_SRC_TIMER = 3'b001,
    ALT_SRC_X     = 3'b010,
    ALT_SRC_Y     = 3'b011,
    ALT_SRC_Z     = 3'b100
  } alt_src_t;
endpackage
`default_nettype wire

// [verilog/alt_decode.sv]
// instruction decoder selecting the accumulator source
`timescale 1ns/100ps
`default_nettype none
module alt_decode
  import alt_pkg::*;
(
  input  wire logic [ALT_INSN_W-1:0] insn_in,
  output alt_src_t                   src_out
);
  // exact ten-bit match only; any other word leaves the accumulator alone
  always_comb begin
    if (insn_in == ALT_OP_TIMER_SIX) begin
      src_out = ALT_SRC_TIMER;
    end else if (insn_in == ALT_OP_X) begin
      src_out = ALT_SRC_X;
    end else if (insn_in == ALT_OP_Y) begin
      src_out = ALT_SRC_Y;
    end else if (insn_in == ALT_OP_Z) begin
      src_out = ALT_SRC_Z;
    end else begin
      src_out = ALT_SRC_NONE;
    end
  end
endmodule // alt_decode
`default_nettype wire

// [verilog/alt_core.sv]
// accumulator load transfer execute stage
`timescale 1ns/100ps
`default_nettype none
module alt_core
  import alt_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  rstn_in,
  input  wire logic                  insn_valid_in,
  input  wire logic [ALT_INSN_W-1:0] insn_in,
  input  wire logic [ALT_DATA_W-1:0] timer_control_six_in,
  input  wire logic [ALT_DATA_W-1:0] x_reg_in,
  input  wire logic [ALT_DATA_W-1:0] y_reg_in,
  input  wire logic [ALT_Z_W-1:0]    z_reg_in,
  input  wire logic                  carry_flag_in,
  output logic      [ALT_DATA_W-1:0] acc_out,
  output logic                       acc_load_out,
  output logic                       carry_flag_out,
  output logic                       skip_next_out,
  output logic                       insn_done_out
);
  // ****************
  // decode
  // ****************
  alt_src_t                  src;
  logic     [ALT_DATA_W-1:0] acc_d;
  logic                      hit;

  alt_decode u_decode (
    .insn_in (insn_in),
    .src_out (src)
  );

  // one place decides what counts as a transfer, for the logic and its checks
  function automatic logic alt_is_load(input logic valid, input alt_src_t sel);
    return valid && (sel != ALT_SRC_NONE);
  endfunction

  assign hit = alt_is_load(insn_valid_in, src);

  always_comb begin
    case (src)
      ALT_SRC_TIMER: acc_d = timer_control_six_in;
      ALT_SRC_X:     acc_d = x_reg_in;
      ALT_SRC_Y:     acc_d = y_reg_in;
      ALT_SRC_Z:     acc_d = {ALT_ZEXT_HI, z_reg_in};
      default:       acc_d = acc_out;
    endcase
  end

  // ****************
  // execute
  // ****************
  // accumulator is held here; x, y, z and timer sources are only read
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      acc_out <= ALT_ACC_RESET;
    end else if (hit) begin
      acc_out <= acc_d;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      acc_load_out  <= 1'b0;
      insn_done_out <= 1'b0;
    end else begin
      acc_load_out  <= hit;
      insn_done_out <= hit;
    end
  end

  // carry passes through untouched; a registered copy keeps outputs flopped
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      carry_flag_out <= 1'b0;
      skip_next_out  <= 1'b0;
    end else begin
      carry_flag_out <= carry_flag_in;
      skip_next_out  <= 1'b0;
    end
  end

  // ****************
  // reference for checks
  // ****************
  // a second, separate match of the words, so a decoder fault cannot hide
  function automatic alt_src_t alt_ref_src(input logic [ALT_INSN_W-1:0] word);
    alt_src_t sel;
    sel = ALT_SRC_NONE;
    if (word == ALT_OP_TIMER_SIX) begin
      sel = ALT_SRC_TIMER;
    end else if (word == ALT_OP_X) begin
      sel = ALT_SRC_X;
    end else if (word == ALT_OP_Y) begin
      sel = ALT_SRC_Y;
    end else if (word == ALT_OP_Z) begin
      sel = ALT_SRC_Z;
    end
    return sel;
  endfunction

  alt_src_t                  ref_src;
  logic                      ref_hit;
  logic     [ALT_DATA_W-1:0] ref_acc_d;
  logic     [ALT_DATA_W-1:0] ref_acc_q;

  assign ref_src = alt_ref_src(insn_in);
  assign ref_hit = alt_is_load(insn_valid_in, ref_src);

  always_comb begin
    ref_acc_d = ref_acc_q;
    if (ref_hit) begin
      if (ref_src == ALT_SRC_TIMER) begin
        ref_acc_d = timer_control_six_in;
      end else if (ref_src == ALT_SRC_X) begin
        ref_acc_d = x_reg_in;
      end else if (ref_src == ALT_SRC_Y) begin
        ref_acc_d = y_reg_in;
      end else begin
        ref_acc_d[ALT_Z_W-1:0]          = z_reg_in;
        ref_acc_d[ALT_DATA_W-1:ALT_Z_W] = ALT_ZEXT_HI;
      end
    end
  end

  // reference only feeds the checks; it drives no output
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ref_acc_q <= ALT_ACC_RESET;
    end else begin
      ref_acc_q <= ref_acc_d;
    end
  end

  // ****************
  // checks
  // ****************
  AST_TIMER: assert property (@(posedge clk_in) disable iff (!rstn_in)
    insn_valid_in && insn_in == ALT_OP_TIMER_SIX |=> acc_out == $past(timer_control_six_in))
    else $error("timer six load wrong");
  AST_X: assert property (@(posedge clk_in) disable iff (!rstn_in)
    insn_valid_in && insn_in == ALT_OP_X |=> acc_out == $past(x_reg_in))
    else $error("x load wrong");
  AST_Y: assert property (@(posedge clk_in) disable iff (!rstn_in)
    insn_valid_in && insn_in == ALT_OP_Y |=> acc_out == $past(y_reg_in))
    else $error("y load wrong");
  AST_Z_LOW: assert property (@(posedge clk_in) disable iff (!rstn_in)
    insn_valid_in && insn_in == ALT_OP_Z |=> acc_out[1:0] == $past(z_reg_in))
    else $error("z low bits wrong");
  AST_Z_HIGH: assert property (@(posedge clk_in) disable iff (!rstn_in)
    insn_valid_in && insn_in == ALT_OP_Z |=> acc_out[3:2] == 2'h0)
    else $error("z high bits not cleared");
  AST_ONE_CYCLE: assert property (@(posedge clk_in) disable iff (!rstn_in)
    hit |=> insn_done_out ##1 (insn_done_out == $past(hit)))
    else $error("transfer not single cycle");
  AST_NO_SKIP: assert property (@(posedge clk_in) disable iff (!rstn_in)
    hit |=> !skip_next_out [*2])
    else $error("skip raised");
  AST_CARRY: assert property (@(posedge clk_in) disable iff (!rstn_in)
    hit |=> carry_flag_out == $past(carry_flag_in))
    else $error("carry changed");
  AST_HOLD: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !hit |=> $stable(acc_out))
    else $error("accumulator changed without transfer");

  // against the separate reference and its own word match
  AST_REF_ACC: assert property (@(posedge clk_in) disable iff (!rstn_in)
    acc_out == ref_acc_q)
    else $error("accumulator differs from reference");
  AST_SRC_MATCH: assert property (@(posedge clk_in) disable iff (!rstn_in)
    insn_valid_in |-> src == ref_src)
    else $error("decoder picked wrong source");
  AST_REFUSE: assert property (@(posedge clk_in) disable iff (!rstn_in)
    insn_valid_in && src == ALT_SRC_NONE |=> !acc_load_out && !insn_done_out)
    else $error("pulse on a refused word");
  AST_IDLE: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !insn_valid_in |=> !acc_load_out && $stable(acc_out))
    else $error("transfer without valid");
  AST_LOAD_PULSE: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ref_hit |=> acc_load_out && insn_done_out)
    else $error("transfer gave no pulse");
  AST_CARRY_IDLE: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !hit |=> carry_flag_out == $past(carry_flag_in))
    else $error("carry changed on idle cycle");
  AST_DONE_LOAD: assert property (@(posedge clk_in) disable iff (!rstn_in)
    insn_done_out == acc_load_out)
    else $error("done and load disagree");
  AST_SKIP_LOW: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !skip_next_out)
    else $error("skip output raised");

  // reset is asynchronous, so outputs are already clear at the first edge in reset
  AST_RESET_VAL: assert property (@(posedge clk_in)
    !rstn_in |-> acc_out == ALT_ACC_RESET && !acc_load_out && !insn_done_out
      && !carry_flag_out && !skip_next_out)
    else $error("output not cleared in reset");

  // bit by bit, so a single stuck enable shows on its own bit
  for (genvar b = 0; b < ALT_DATA_W; b++) begin : g_acc_bit
    AST_BIT_HOLD: assert property (@(posedge clk_in) disable iff (!rstn_in)
      !ref_hit |=> $stable(acc_out[b]))
      else $error("accumulator bit moved without transfer");
  end

  // ****************
  // coverage
  // ****************
  COV_TIMER: cover property (@(posedge clk_in) insn_valid_in && insn_in == ALT_OP_TIMER_SIX);
  COV_Z: cover property (@(posedge clk_in) insn_valid_in && insn_in == ALT_OP_Z);
  COV_BACK: cover property (@(posedge clk_in) hit ##1 hit);
  COV_X: cover property (@(posedge clk_in) insn_valid_in && insn_in == ALT_OP_X);
  COV_REFUSE: cover property (@(posedge clk_in) insn_valid_in && src == ALT_SRC_NONE);
endmodule // alt_core
`default_nettype wire

// [verif/alt_core_bench.sv]
// self-checking bench for the accumulator load transfer block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module alt_core_bench;
  import alt_pkg::*;
  logic       clk_in = 1'b0, rstn_in, insn_valid_in = 1'b0, carry_flag_in = 1'b0;
  logic [9:0] insn_in = 10'h000;
  logic [3:0] timer_control_six_in = 4'ha, x_reg_in = 4'h5, y_reg_in = 4'hc, acc_out;
  logic [1:0] z_reg_in = 2'h3;
  logic       acc_load_out, carry_flag_out, skip_next_out, insn_done_out;
  int         mismatches = 0, cmp_count = 0;
  alt_core dut (.clk_in(clk_in), .rstn_in(rstn_in), .insn_valid_in(insn_valid_in),
    .insn_in(insn_in), .timer_control_six_in(timer_control_six_in), .x_reg_in(x_reg_in),
    .y_reg_in(y_reg_in), .z_reg_in(z_reg_in), .carry_flag_in(carry_flag_in),
    .acc_out(acc_out), .acc_load_out(acc_load_out), .carry_flag_out(carry_flag_out),
    .skip_next_out(skip_next_out), .insn_done_out(insn_done_out));
  initial forever #5 clk_in = ~clk_in;
  // ********************
  // one word every two cycles, carry toggled so a stuck carry path shows
  // ********************
  task automatic run(input logic val, input logic [9:0] w, input logic [3:0] ea,
                     input logic ep);
    @(posedge clk_in);
    insn_valid_in <= val;
    insn_in       <= w;
    carry_flag_in <= ~carry_flag_in;
    @(posedge clk_in);
    #1;
    `CHK(acc_out, ea)
    `CHK(acc_load_out, ep)
    `CHK(insn_done_out, ep)
    `CHK(carry_flag_out, carry_flag_in)
    `CHK(skip_next_out, 1'b0)
  endtask
  task automatic t_regs();
    run(1'b1, ALT_OP_TIMER_SIX, 4'ha, 1'b1);
    run(1'b1, ALT_OP_X, 4'h5, 1'b1);
    run(1'b1, ALT_OP_Y, 4'hc, 1'b1);
    @(posedge clk_in);
    x_reg_in <= 4'h9;
    run(1'b1, ALT_OP_X, 4'h9, 1'b1);
    $display("test regs done");
  endtask
  task automatic t_zext();
    @(posedge clk_in);
    y_reg_in <= 4'hf;
    run(1'b1, ALT_OP_Y, 4'hf, 1'b1);
    run(1'b1, ALT_OP_Z, 4'h3, 1'b1);
    @(posedge clk_in);
    z_reg_in <= 2'h2;
    run(1'b1, ALT_OP_Z, 4'h2, 1'b1);
    $display("test zext done");
  endtask
  task automatic t_refuse();
    run(1'b1, 10'h054, 4'h2, 1'b0);
    run(1'b0, ALT_OP_X, 4'h2, 1'b0);
    run(1'b1, 10'h250 ^ 10'h200, 4'h2, 1'b0);
    run(1'b1, ALT_OP_X, 4'h9, 1'b1);
    $display("test refuse done");
  endtask
  // reset in mid-run with a transfer waiting; it must run at the first edge after release
  task automatic t_reset();
    @(posedge clk_in);
    rstn_in       <= 1'b0;
    insn_valid_in <= 1'b1;
    insn_in       <= ALT_OP_Y;
    @(posedge clk_in);
    #1;
    `CHK(acc_out, ALT_ACC_RESET)
    `CHK(acc_load_out, 1'b0)
    `CHK(insn_done_out, 1'b0)
    `CHK(carry_flag_out, 1'b0)
    `CHK(skip_next_out, 1'b0)
    @(posedge clk_in);
    rstn_in <= 1'b1;
    #1;
    `CHK(acc_out, ALT_ACC_RESET)
    `CHK(acc_load_out, 1'b0)
    @(posedge clk_in);
    #1;
    `CHK(acc_out, 4'hf)
    `CHK(insn_done_out, 1'b1)
    @(posedge clk_in);
    #1;
    `CHK(acc_out, 4'hf)
    `CHK(carry_flag_out, carry_flag_in)
    run(1'b1, ALT_OP_X, 4'h9, 1'b1);
    $display("test reset done");
  endtask
  // ********************
  // verdict
  // ********************
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    rstn_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_regs();
    t_zext();
    t_refuse();
    t_reset();
    finish_test();
  end
  // tests need well under 100 cycles; generous margin
  initial begin
    #20us;
    mismatches++;
    finish_test();
  end
endmodule // alt_core_bench
`default_nettype wire
